// [rtl/config_images.sv]
/*
 Active range image and prior control snapshot, updated by the refresh
 event. Assumes the command decoder issues a one-cycle REFRESH pulse and
 that the programmed source words are held stable by the register file.
*/
`timescale 1ns/1ps
module config_images #(
    parameter int SETTLE_CYCLES = image_regs_pkg::SETTLE_CYCLES
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Programmed source words and refresh event
    input wire logic [15:0] RANGE_PROG,
    input wire logic [15:0] CONTROL_PROG,
    input wire logic REFRESH,
    // Register read port
    input wire logic [7:0] RD_ADDR,
    output logic [15:0] RD_DATA,
    output logic RD_HIT,
    // Images and status
    output logic [15:0] ACTIVE_RANGE,
    output logic [15:0] CONTROL_ACT,
    output logic [15:0] PRIOR_CONTROL,
    output logic IMAGES_VALID,
    output logic SNAPSHOT_VALID
);

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam int NCH = image_regs_pkg::NUM_CH;
    localparam int FW = image_regs_pkg::FIELD_W;
    localparam int MODE_W = $bits(RD_DATA) - image_regs_pkg::MODE_LSB;
    localparam int PIN_W = image_regs_pkg::PIN2_LSB - image_regs_pkg::PIN1_LSB;
    localparam int INACT_W = image_regs_pkg::PIN1_LSB
        - image_regs_pkg::INACTIVE_LSB;

    // A zero settle time would flag the images valid in the cycle right after the refresh
    if (SETTLE_CYCLES < 1)
    begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    // The sense fields must end just above the bus fields, and the bus
    // fields must end at bit 0, or some range bits would be left undriven
    if (image_regs_pkg::SENSE_MSB_CH1 - FW * NCH
        != image_regs_pkg::BUS_MSB_CH1)
    begin : g_bad_sense_layout
        $error("Sense range fields do not meet the bus range fields");
    end

    if (image_regs_pkg::BUS_MSB_CH1 - FW * NCH != -1)
    begin : g_bad_bus_layout
        $error("Bus range fields do not end at bit 0");
    end

    // The snapshot word is read back whole, so it must fill the data bus
    if ($bits(image_regs_pkg::control_word_t) != $bits(RD_DATA))
    begin : g_bad_snapshot_width
        $error("Control word does not match the read data width");
    end

    // Registers
    logic [15:0] range_r;
    logic [15:0] control_r;
    image_regs_pkg::control_word_t snap_r;
    logic [CW-1:0] settle_r;
    logic snap_seen_r;
    logic [15:0] rd_data_r;

    // Next values
    logic [15:0] range_nxt;
    logic [15:0] control_nxt;
    image_regs_pkg::control_word_t snap_nxt;
    logic [CW-1:0] settle_nxt;
    logic snap_seen_nxt;
    logic [15:0] rd_data_nxt;

    // Decode and selection
    wire [15:0] range_clean;
    image_regs_pkg::control_word_t snap_fields;
    logic settle_busy;
    wire hit_range = RD_ADDR == image_regs_pkg::ADDR_ACTIVE_RANGE;
    wire hit_snap = RD_ADDR == image_regs_pkg::ADDR_PRIOR_CONTROL;
    wire hit_ctrl = RD_ADDR == image_regs_pkg::ADDR_CONTROL_ACT;

    // Per-channel field copy; each field passes whole, reserved code too,
    // so software can see exactly what was programmed
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            localparam int SH = image_regs_pkg::SENSE_MSB_CH1 - FW * ch;
            localparam int BH = image_regs_pkg::BUS_MSB_CH1 - FW * ch;
            assign range_clean[SH -: image_regs_pkg::FIELD_W] =
                RANGE_PROG[SH -: image_regs_pkg::FIELD_W];
            assign range_clean[BH -: image_regs_pkg::FIELD_W] =
                RANGE_PROG[BH -: image_regs_pkg::FIELD_W];
        end
    endgenerate

    // Old active control, laid out field by field; the low nibble stays zero
    assign snap_fields = '{
        sample_mode: control_r[image_regs_pkg::MODE_LSB +: MODE_W],
        pin2_function: control_r[image_regs_pkg::PIN2_LSB +: PIN_W],
        pin1_function: control_r[image_regs_pkg::PIN1_LSB +: PIN_W],
        channel_inactive: control_r[image_regs_pkg::INACTIVE_LSB +: INACT_W],
        unused: '0
    };

    // The snapshot only changes on a refresh, taking the old control at the same edge the new control lands
    assign snap_nxt = REFRESH ? snap_fields : snap_r;

    // Range image only moves on a refresh, never on a source write
    assign range_nxt = REFRESH ? range_clean : range_r;

    // Newly programmed control becomes active at the refresh edge
    assign control_nxt = REFRESH ? CONTROL_PROG : control_r;

    // Set by the first refresh; only reset clears it
    assign snap_seen_nxt = snap_seen_r | REFRESH;

    // Counter restarts on each refresh; a refresh during settling extends it
    assign settle_busy = settle_r != '0;
    assign settle_nxt = REFRESH ? CW'(SETTLE_CYCLES)
        : (settle_busy ? settle_r - CW'(1) : settle_r);

    // Unmapped addresses read zero; the data is registered, so a read
    // returns one cycle after the address
    assign rd_data_nxt = hit_range ? range_r
        : hit_snap ? 16'(snap_r)
        : hit_ctrl ? control_r : 16'h0000;

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            range_r <= image_regs_pkg::RANGE_RESET;
        end
        else
        begin
            range_r <= range_nxt;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            control_r <= image_regs_pkg::CONTROL_RESET;
        end
        else
        begin
            control_r <= control_nxt;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            snap_r <= image_regs_pkg::control_word_t'(
                image_regs_pkg::SNAPSHOT_RESET);
        end
        else
        begin
            snap_r <= snap_nxt;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            snap_seen_r <= 1'b0;
        end
        else
        begin
            snap_seen_r <= snap_seen_nxt;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            settle_r <= '0;
        end
        else
        begin
            settle_r <= settle_nxt;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            rd_data_r <= 16'h0000;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign RD_DATA = rd_data_r;
    assign RD_HIT = hit_range | hit_snap | hit_ctrl;
    assign ACTIVE_RANGE = range_r;
    assign CONTROL_ACT = control_r;
    assign PRIOR_CONTROL = snap_r;
    assign IMAGES_VALID = snap_seen_r && !settle_busy;
    assign SNAPSHOT_VALID = IMAGES_VALID;

endmodule

// [shared/image_regs_pkg.sv]
/*
 Package for the active range and prior control snapshot registers:
 register offsets, field positions, reset values, range encodings, timing.
 Assumes a 100 MHz system clock.
*/
package image_regs_pkg;

    localparam int NUM_CH = 4;
    localparam logic [7:0] ADDR_CONTROL_PROG = 8'h01;
    localparam logic [7:0] ADDR_RANGE_PROG = 8'h1D;
    localparam logic [7:0] ADDR_CONTROL_ACT = 8'h21;
    localparam logic [7:0] ADDR_ACTIVE_RANGE = 8'h22;
    localparam logic [7:0] ADDR_PRIOR_CONTROL = 8'h23;

    localparam logic [15:0] RANGE_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_RESET = 16'h0700;
    localparam logic [15:0] SNAPSHOT_RESET = 16'h0000;
    localparam logic [15:0] SNAPSHOT_MASK = 16'hFFF0;

    localparam int SENSE_MSB_CH1 = 15;
    localparam int BUS_MSB_CH1 = 7;
    localparam int FIELD_W = 2;

    localparam int MODE_LSB = 12;
    localparam int PIN2_LSB = 10;
    localparam int PIN1_LSB = 8;
    localparam int INACTIVE_LSB = 4;

    typedef enum logic [1:0]
    {
        RANGE_UNIPOLAR = 2'h0,
        RANGE_BIPOLAR_FULL = 2'h1,
        RANGE_BIPOLAR_HALF = 2'h2,
        RANGE_RESERVED = 2'h3
    } full_scale_range_t;

    typedef struct packed
    {
        logic [3:0] sample_mode;
        logic [1:0] pin2_function;
        logic [1:0] pin1_function;
        logic [3:0] channel_inactive;
        logic [3:0] unused;
    } control_word_t;

    localparam int CLK_MHZ = 100;
    localparam int SETTLE_TIME_US = 1000;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;

endpackage

// [sim/config_images_asserts.sv]
/* Checker for the range image and the prior control snapshot.
 Assumes SETTLE_CYCLES is 8, as the bench sets it. */
`timescale 1ns/1ps
module config_images_asserts #(parameter int SETTLE_CYCLES = 8)
(
    // Clock, reset and strobes
    input wire logic CLOCK, SRST, REFRESH, RD_HIT,
    input wire logic IMAGES_VALID, SNAPSHOT_VALID,
    // Words
    input wire logic [15:0] RANGE_PROG, CONTROL_PROG, RD_DATA,
    input wire logic [15:0] ACTIVE_RANGE, CONTROL_ACT, PRIOR_CONTROL,
    input wire logic [7:0] RD_ADDR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    a_range_load: assert property
        (REFRESH |=> ACTIVE_RANGE == $past(RANGE_PROG)) else $error("load");
    a_range_hold: assert property
        (!REFRESH |=> $stable(ACTIVE_RANGE)) else $error("range moved");
    a_snap_load: assert property
        (REFRESH |=> PRIOR_CONTROL
            == ($past(CONTROL_ACT) & image_regs_pkg::SNAPSHOT_MASK))
        else $error("snapshot");
    a_snap_low: assert property
        (PRIOR_CONTROL[3:0] == 4'h0) else $error("low bits");
    a_ctrl_load: assert property
        (REFRESH |=> CONTROL_ACT == $past(CONTROL_PROG))
        else $error("control");
    a_valid_wait: assert property
        (REFRESH |=> !IMAGES_VALID[*8]) else $error("valid early");
    a_valid_cause: assert property
        ($rose(SNAPSHOT_VALID) |-> $past(REFRESH, 9)) else $error("valid");
    a_reset_vals: assert property
        ($past(SRST) |-> ACTIVE_RANGE == 16'h0000 && !SNAPSHOT_VALID)
        else $error("reset");
    a_read_range: assert property
        (RD_ADDR == 8'h22 |=> RD_DATA == $past(ACTIVE_RANGE)) else $error("rd");
    cover property (REFRESH ##1 REFRESH);
    cover property ($rose(IMAGES_VALID));
    cover property (RD_HIT && RD_ADDR == 8'h23);
endmodule
bind config_images config_images_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES))
    chk_inst(.CLOCK, .SRST, .REFRESH, .RD_HIT, .IMAGES_VALID,
    .SNAPSHOT_VALID, .RANGE_PROG, .CONTROL_PROG, .RD_DATA, .ACTIVE_RANGE,
    .CONTROL_ACT, .PRIOR_CONTROL, .RD_ADDR);

// [sim/host_model.sv]
/* Host reader model for the image registers.
 Assumes the bench supplies the wanted address. */
`timescale 1ns/1ps
module host_model
(
    input wire logic valid,
    input wire logic [7:0] want,
    output logic [7:0] rd_addr
);
    // Held at an unmapped address until valid, so stale images are not read
    assign rd_addr = valid ? want : 8'h00;
endmodule

// [sim/active_latched_config_images_tb_top.sv]
/* Bench for the range image and control snapshot.
 Assumes the design is built with SETTLE_CYCLES of 8. */
`timescale 1ns/1ps
module active_latched_config_images_tb_top;
    logic clock = 0, srst = 1, refresh = 0, hit, img_v, snap_v;
    logic [15:0] rprog = 0, cprog = 0, rd_data, act, ctl, prior;
    logic [7:0] want = 0, rd_addr;
    int mismatches = 0, check_count = 0;
    // Range, control to program, snapshot expected
    logic [15:0] rows [3][3] = '{'{16'h1B1B, 16'hB3AF, 16'h0700},
        '{16'hE4E4, 16'h4C5A, 16'hB3A0}, '{16'h9C36, 16'hF0FF, 16'h4C50}};
    always #5 clock = ~clock;
    config_images #(.SETTLE_CYCLES(8)) config_images_inst(.CLOCK(clock),
        .SRST(srst), .RANGE_PROG(rprog), .CONTROL_PROG(cprog),
        .REFRESH(refresh), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
        .RD_HIT(hit), .ACTIVE_RANGE(act), .CONTROL_ACT(ctl),
        .PRIOR_CONTROL(prior), .IMAGES_VALID(img_v), .SNAPSHOT_VALID(snap_v));
    host_model host_model_inst(.valid(img_v), .want(want), .rd_addr(rd_addr));
    task chk(string n, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task rdchk(string n, logic [7:0] a, logic [15:0] exp);
        want = a;
        repeat (2) @(negedge clock);
        chk(n, rd_data, exp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clock);
        srst = 0;
        chk("reset", act, 16'h0000);
        rprog = 16'hFFFF;
        repeat (3) @(negedge clock);
        chk("unrefreshed", {act[15:1], snap_v}, 16'h0000);
        foreach (rows[i])
        begin
            rprog = rows[i][0];
            cprog = rows[i][1];
            refresh = 1;
            @(negedge clock) refresh = 0;
            repeat (20) if (!img_v) @(negedge clock);
            chk("valid", {15'h0, img_v}, 16'h0001);
            rdchk("range", 8'h22, rows[i][0]);
            chk("hit", {15'h0, hit}, 16'h0001);
            rdchk("snapshot", 8'h23, rows[i][2]);
            rdchk("control", 8'h21, rows[i][1]);
        end
        refresh = 1;
        repeat (2) @(negedge clock);
        refresh = 0;
        chk("twice", {prior[15:1], img_v}, 16'hF0F0);
        chk("control", ctl, 16'hF0FF);
        srst = 1;
        @(negedge clock) srst = 0;
        chk("rerun", act | prior, 16'h0000);
        chk("rerun control", ctl, 16'h0700);
        chk("rerun valid", {15'h0, snap_v}, 16'h0000);
        rdchk("held off", 8'h23, 16'h0000);
        chk("miss", {15'h0, hit}, 16'h0000);
        cprog = 16'h1234;
        refresh = 1;
        @(negedge clock) refresh = 0;
        repeat (20) if (!img_v) @(negedge clock);
        rdchk("first snapshot", 8'h23, 16'h0700);
        end_sim;
    end
    initial
    begin
        #5000 mismatches++;
        end_sim;
    end
endmodule
